//--- hdl/flash_mode_ctrl.sv
// serial flash command front end: mode switch, wrapped read, software reset
// assumes pins are asynchronous to pclk and sclk is slow (>= 6 pclk per phase)
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module flash_mode_ctrl #(
    parameter int RST_COUNT = flash_cmd_pkg::RST_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cs_n_pin,
    input  wire logic        sclk_pin,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    output logic      [23:0] array_addr,
    input  wire logic [7:0]  array_data,
    output logic             quad_mode,
    output logic             reset_busy
);
    import flash_cmd_pkg::*;

    // --------
    // pin synchronisation and edge detection
    // --------
    logic [5:0]  pins_s;
    logic        cs_n_s;
    logic        sclk_s;
    logic [3:0]  io_s;
    logic        sclk_prev_reg;
    logic        sclk_rise;
    logic        sclk_fall;

    pin_sync #(
        .W (6)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({cs_n_pin, sclk_pin, io_in}),
        .q     (pins_s)
    );

    assign cs_n_s = pins_s[5];
    assign sclk_s = pins_s[4];
    assign io_s   = pins_s[3:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    // edges only count while selected; a stray edge outside a frame is dropped
    assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev_reg;
    assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev_reg;

    // --------
    // state declarations
    // --------
    phase_t      phase_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bit_cnt_reg;
    logic [2:0]  cnt_reg;
    logic [7:0]  opcode_reg;
    logic [19:0] addr_sh_reg;
    logic        nib_hi_reg;
    logic        armed_reg;
    logic        quad_en_reg;
    logic        wel_reg;
    logic        sus_reg;
    logic [3:0]  vsr_reg;
    logic [7:0]  param_reg;
    logic [7:0]  crm_reg;
    logic [2:0]  wrapbits_reg;
    logic        cs_prev_reg;
    logic        rst_start_reg;
    logic [7:0]  byte_next;
    logic        last_unit;
    logic        byte_done;
    logic        cs_rise;
    logic        exec;
    logic [3:0]  dummy_n;

    reset_timer #(
        .CYCLES (RST_COUNT)
    ) u_rst (
        .clk   (pclk),
        .rst_n (presetn),
        .start (rst_start_reg),
        .busy  (reset_busy)
    );

    // --------
    // instruction byte assembly
    // --------
    // one format at a time: serial shifts io0, quad shifts all four lines
    assign byte_next = quad_mode ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]}; // see R4
    assign last_unit = quad_mode ? (bit_cnt_reg == 3'h1) : (bit_cnt_reg == 3'h7);
    assign byte_done = sclk_rise && last_unit && !reset_busy; // see R15
    assign cs_rise   = cs_n_s && !cs_prev_reg;
    assign exec      = cs_rise && (phase_reg == PH_HOLD) && !reset_busy;
    assign dummy_n   = dummy_clocks(param_reg[DUMMY_SEL_LSB +: 2]); // see R2

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_prev_reg <= 1'b1;
        end else begin
            cs_prev_reg <= cs_n_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 3'h0;
        end else if (cs_n_s) begin
            bit_cnt_reg <= 3'h0;
        end else if (sclk_rise) begin
            shift_reg   <= byte_next;
            bit_cnt_reg <= last_unit ? 3'h0 : bit_cnt_reg + 3'h1;
        end
    end

    // --------
    // phase sequencing
    // --------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg  <= PH_CMD;
            opcode_reg <= 8'h00;
            cnt_reg    <= 3'h0;
        end else if (reset_busy || rst_start_reg) begin
            phase_reg <= PH_IGNORE; // see R11 see R15
        end else if (cs_n_s) begin
            phase_reg <= PH_CMD;
            cnt_reg   <= 3'h0;
        end else begin
            unique case (phase_reg)
                PH_CMD: begin
                    if (byte_done) begin
                        opcode_reg <= byte_next;
                        cnt_reg    <= 3'h0;
                        unique case (byte_next)
                            OP_WRAP_READ:  phase_reg <= quad_mode ? PH_ADDR : PH_IGNORE;
                            OP_SET_PARAM:  phase_reg <= quad_mode ? PH_PARAM : PH_IGNORE; // see R19
                            OP_ENTER_QUAD: phase_reg <= quad_mode ? PH_IGNORE : PH_HOLD;
                            OP_EXIT_QUAD:  phase_reg <= quad_mode ? PH_HOLD : PH_IGNORE;
                            OP_RST_ENABLE: phase_reg <= PH_HOLD; // see R13
                            OP_RESET:      phase_reg <= PH_HOLD; // see R13
                            default:       phase_reg <= PH_IGNORE;
                        endcase
                    end
                end
                PH_PARAM: begin
                    if (byte_done) begin
                        phase_reg <= PH_HOLD;
                    end
                end
                PH_HOLD: begin
                    // clocks beyond the last byte void the instruction
                    if (sclk_rise) begin
                        phase_reg <= PH_IGNORE;
                    end
                end
                PH_ADDR: begin
                    if (sclk_rise) begin
                        if (cnt_reg == ADDR_NIBBLES - 3'h1) begin
                            phase_reg <= PH_DUMMY;
                            cnt_reg   <= 3'h0;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                end
                PH_DUMMY: begin
                    if (sclk_rise) begin
                        if ({1'b0, cnt_reg} == dummy_n - 4'h1) begin
                            phase_reg <= PH_DATA; // see R2
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                end
                PH_DATA: phase_reg <= PH_DATA;
                PH_IGNORE: phase_reg <= PH_IGNORE;
                default: phase_reg <= PH_IGNORE;
            endcase
        end
    end

    // --------
    // mode, reset arming and reset start
    // --------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_mode     <= 1'b0; // see R5
            armed_reg     <= 1'b0;
            rst_start_reg <= 1'b0;
        end else begin
            rst_start_reg <= 1'b0;
            if (rst_start_reg) begin
                quad_mode <= 1'b0; // see R20
                armed_reg <= 1'b0; // see R20
            end else if (byte_done && phase_reg == PH_CMD &&
                         byte_next != OP_RESET && byte_next != OP_RST_ENABLE) begin
                armed_reg <= 1'b0; // see R14
            end else if (exec) begin
                unique case (opcode_reg)
                    OP_ENTER_QUAD: begin
                        if (quad_en_reg) begin
                            quad_mode <= 1'b1; // see R3 see R7
                        end
                        armed_reg <= 1'b0;
                    end
                    OP_EXIT_QUAD: begin
                        quad_mode <= 1'b0; // see R9
                        armed_reg <= 1'b0;
                    end
                    OP_RST_ENABLE: armed_reg <= 1'b1;
                    OP_RESET: begin
                        rst_start_reg <= armed_reg; // see R14
                        armed_reg     <= 1'b0;
                    end
                    default: armed_reg <= 1'b0;
                endcase
            end
        end
    end

    // --------
    // volatile settings: mode switches never touch these
    // --------
    logic        apb_wr;
    logic        apb_setup;

    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_reg <= PARAM_RESET; // see R17
        end else if (rst_start_reg) begin
            param_reg <= PARAM_RESET; // see R12 see R17
        end else if (exec && opcode_reg == OP_SET_PARAM) begin
            param_reg <= shift_reg; // see R2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wel_reg      <= 1'b0;
            sus_reg      <= 1'b0;
            vsr_reg      <= 4'h0;
            crm_reg      <= CRM_RESET;
            wrapbits_reg <= WRAPBITS_RESET;
        end else if (rst_start_reg) begin
            wel_reg      <= 1'b0; // see R12
            sus_reg      <= 1'b0; // see R12
            vsr_reg      <= 4'h0; // see R12
            crm_reg      <= CRM_RESET; // see R12
            wrapbits_reg <= WRAPBITS_RESET; // see R12
        end else if (apb_wr) begin
            // held across quad entry and exit on purpose
            if (paddr == ADDR_CTRL) begin
                wel_reg <= pwdata[CTRL_WEL_BIT]; // see R8 see R10
                sus_reg <= pwdata[CTRL_SUS_BIT];
                vsr_reg <= pwdata[CTRL_VSR_LSB +: VSR_W];
            end
            if (paddr == ADDR_MODE) begin
                crm_reg      <= pwdata[MODE_CRM_LSB +: 8];
                wrapbits_reg <= pwdata[MODE_WRAP_LSB +: 3];
            end
        end
    end

    // quad enable lives in non-volatile status, so software reset leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_en_reg <= 1'b0;
        end else if (apb_wr && paddr == ADDR_CTRL) begin
            quad_en_reg <= pwdata[CTRL_QE_BIT];
        end
    end

    // --------
    // wrapped read address and data out
    // --------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_sh_reg <= 20'h0_0000;
            array_addr  <= 24'h00_0000;
        end else if (phase_reg == PH_ADDR && sclk_rise) begin
            addr_sh_reg <= {addr_sh_reg[15:0], io_s};
            if (cnt_reg == ADDR_NIBBLES - 3'h1) begin
                array_addr <= {addr_sh_reg, io_s};
            end
        end else if (phase_reg == PH_DATA && sclk_fall && !nib_hi_reg) begin
            array_addr <= wrap_next(array_addr, param_reg[WRAP_SEL_LSB +: 2]); // see R1 see R2
        end
    end

    // array_data follows array_addr well before the next falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_out     <= 4'h0;
            io_oe      <= 4'h0;
            nib_hi_reg <= 1'b1;
        end else if (phase_reg != PH_DATA || reset_busy) begin
            io_oe      <= 4'h0;
            nib_hi_reg <= 1'b1;
        end else if (sclk_fall) begin
            io_out     <= nib_hi_reg ? array_data[7:4] : array_data[3:0];
            io_oe      <= 4'hF;
            nib_hi_reg <= !nib_hi_reg;
        end
    end

    // --------
    // apb slave, zero wait states
    // --------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (apb_setup) begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
                unique case (paddr)
                    ADDR_CTRL: begin
                        prdata[CTRL_QE_BIT]             <= quad_en_reg;
                        prdata[CTRL_WEL_BIT]            <= wel_reg;
                        prdata[CTRL_SUS_BIT]            <= sus_reg;
                        prdata[CTRL_VSR_LSB +: VSR_W]   <= vsr_reg;
                    end
                    ADDR_STATUS: begin
                        prdata[STAT_QUAD_BIT] <= quad_mode;
                        prdata[STAT_ARM_BIT]  <= armed_reg;
                        prdata[STAT_BUSY_BIT] <= reset_busy;
                    end
                    ADDR_PARAM:  prdata[7:0] <= param_reg;
                    ADDR_MODE: begin
                        prdata[MODE_CRM_LSB +: 8]  <= crm_reg;
                        prdata[MODE_WRAP_LSB +: 3] <= wrapbits_reg;
                    end
                    ADDR_RDADDR: prdata[23:0] <= array_addr;
                    default:     pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- inc/flash_cmd_pkg.sv
// constants, types and helpers for the serial flash command/mode block
// assumes a 250 MHz pclk and a host that drives chip select, clock and io pins
// What this block does and what it expects of the host
// R1: wrapped burst read returns address to start of the aligned wrap window
// R2: wrap length and dummy count come from the last set-read-parameters load
// R3: only enter-quad-command-mode switches serial mode to four-wire command mode
// R4: exactly one mode at a time, one decode format only
// R5: power-up starts in serial mode
// R6: host sets quad enable bit before enter-quad-command-mode
// R7: enter-quad-command-mode is ignored while quad enable bit is zero
// R8: mode entry keeps write enable latch, suspend state and wrap length
// R9: exit-quad-command-mode returns four-wire command mode to serial mode
// R10: mode exit keeps write enable latch, suspend state and wrap length
// R11: accepted software reset aborts operations, restores power-on defaults except the quad enable bit
// R12: software reset clears all volatile settings and fields
// R13: enable-reset and reset are accepted in both modes
// R14: reset only directly after enable-reset; other instruction disarms
// R15: reset lasts about 30 us and rejects every instruction meanwhile
// R16: host checks busy and suspend bits before the reset pair
// R17: defaults are wrap length 8 bytes and 2 dummy clocks
// R18: select fields encode 2/4/6/8 dummy clocks and 8/16/32/64 byte wraps
// R19: set-read-parameters is rejected in serial mode
// R20: completed reset leaves quad mode with enable-reset disarmed
package flash_cmd_pkg;

    // --------
    // register map
    // --------
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_PARAM     = 8'h08;
    localparam logic [7:0]  ADDR_MODE      = 8'h0C;
    localparam logic [7:0]  ADDR_RDADDR    = 8'h10;
    localparam int          CTRL_QE_BIT    = 0;
    localparam int          CTRL_WEL_BIT   = 1;
    localparam int          CTRL_SUS_BIT   = 2;
    localparam int          CTRL_VSR_LSB   = 4;
    localparam int          VSR_W          = 4;
    localparam int          STAT_QUAD_BIT  = 0;
    localparam int          STAT_ARM_BIT   = 1;
    localparam int          STAT_BUSY_BIT  = 2;
    localparam int          MODE_CRM_LSB   = 0;
    localparam int          MODE_WRAP_LSB  = 8;
    localparam int          DUMMY_SEL_LSB  = 4;
    localparam int          WRAP_SEL_LSB   = 0;
    localparam logic [7:0]  PARAM_RESET    = 8'h00;
    localparam logic [7:0]  CRM_RESET      = 8'h00;
    localparam logic [2:0]  WRAPBITS_RESET = 3'h0;

    // --------
    // instructions
    // --------
    localparam logic [7:0]  OP_WRAP_READ   = 8'h0C;
    localparam logic [7:0]  OP_SET_PARAM   = 8'hC0;
    localparam logic [7:0]  OP_ENTER_QUAD  = 8'h38;
    localparam logic [7:0]  OP_EXIT_QUAD   = 8'hFF;
    localparam logic [7:0]  OP_RST_ENABLE  = 8'h66;
    localparam logic [7:0]  OP_RESET       = 8'h99;
    localparam logic [2:0]  ADDR_NIBBLES   = 3'h6;

    // --------
    // timing
    // --------
    localparam int          CLK_PERIOD_PS  = 4000;
    localparam int          RST_TIME_NS    = 30000;
    localparam int          RST_CYCLES     = (RST_TIME_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        PH_CMD    = 3'b000,
        PH_ADDR   = 3'b001,
        PH_DUMMY  = 3'b011,
        PH_DATA   = 3'b010,
        PH_HOLD   = 3'b110,
        PH_PARAM  = 3'b100,
        PH_IGNORE = 3'b111
    } phase_t;

    // 00..11 -> 2,4,6,8 dummy clocks
    function automatic logic [3:0] dummy_clocks(input logic [1:0] sel);
        dummy_clocks = {1'b0, sel, 1'b0} + 4'h2; // see R18
    endfunction

    // increment inside the 8/16/32/64 byte window selected by sel
    function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic [1:0] sel);
        logic [23:0] mask;
        mask = (24'h00_0008 << sel) - 24'h00_0001; // see R18
        wrap_next = (a & ~mask) | ((a + 24'h00_0001) & mask); // see R1
    endfunction

endpackage

//--- hdl/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes each bit is independent; multi-bit coherence is not provided
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

//--- hdl/reset_timer.sv
// recovery timer started by an accepted software reset
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module reset_timer #(
    parameter int CYCLES = 7500
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy      <= 1'b0;
            count_reg <= '0;
        end else if (start) begin
            busy      <= 1'b1;
            count_reg <= W'(CYCLES - 1); // see R15
        end else if (busy) begin
            if (count_reg == '0) begin
                busy <= 1'b0;
            end else begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/flash_mode_ctrl_asserts.sv
// checker for the flash mode controller: mode switching, drive and reset recovery
// assumes binding to flash_mode_ctrl and cs idle >= 8 pclk between frames
`timescale 1ns/1ps
`default_nettype none
module flash_mode_ctrl_asserts #(
    parameter int RST_COUNT = 50
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       cs_n_pin,
    input wire logic [3:0] io_oe,
    input wire logic       quad_mode,
    input wire logic       reset_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------
    // helpers
    // --------
    // counter, since a long repetition would be unrolled by the tools
    logic [15:0] busy_cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_cnt_reg <= 16'h0000;
        else
            busy_cnt_reg <= reset_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
    end
    sequence s_cs_settled;
        cs_n_pin && $past(cs_n_pin, 3);
    endsequence
    // --------
    // properties
    // --------
    property p_mode_entry;
        $rose(quad_mode) |-> !reset_busy ##0 s_cs_settled;
    endproperty
    property p_mode_exit;
        $fell(quad_mode) |-> s_cs_settled;
    endproperty
    property p_one_mode;
        $rose(io_oe[0]) |-> quad_mode;
    endproperty
    property p_oe_whole;
        io_oe == 4'h0 || io_oe == 4'hF;
    endproperty
    property p_busy_start;
        $rose(reset_busy) |-> s_cs_settled ##1 !quad_mode;
    endproperty
    property p_busy_len;
        $fell(reset_busy) |-> busy_cnt_reg >= RST_COUNT - 1 && busy_cnt_reg <= RST_COUNT + 1;
    endproperty
    property p_busy_quiet;
        reset_busy && $past(reset_busy) |-> !quad_mode;
    endproperty
    property p_oe_idle;
        cs_n_pin [*8] |-> io_oe == 4'h0;
    endproperty
    a_mode_entry: assert property (p_mode_entry) else $error("quad entry off frame end");
    a_mode_exit: assert property (p_mode_exit) else $error("quad exit off frame end");
    a_one_mode: assert property (p_one_mode) else $error("drive outside quad mode");
    a_oe_whole: assert property (p_oe_whole) else $error("partial io drive");
    a_busy_start: assert property (p_busy_start) else $error("reset start wrong");
    a_busy_len: assert property (p_busy_len) else $error("reset recovery length");
    a_busy_quiet: assert property (p_busy_quiet) else $error("quad during reset");
    a_oe_idle: assert property (p_oe_idle) else $error("drive while deselected");
endmodule
bind flash_mode_ctrl flash_mode_ctrl_asserts #(.RST_COUNT(RST_COUNT)) u_asserts (
    .pclk(pclk), .presetn(presetn), .cs_n_pin(cs_n_pin), .io_oe(io_oe),
    .quad_mode(quad_mode), .reset_busy(reset_busy)
);
`default_nettype wire

//--- verif/spi_host_model.sv
// serial bus host: frames instructions and wrapped reads, 48 ns link clock
// assumes io is the resolved pin level fed back from the bench
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      h_io,
    input  wire logic [3:0] io
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        h_io = 4'h0;
    end
    // unused lines toggle, so a stale level never reads as valid
    task automatic tick(input logic [3:0] v, input bit q);
        h_io = q ? v : {~h_io[3:1], v[0]};
        #24 sclk = 1'b1;
        #24 sclk = 1'b0;
    endtask
    task automatic put(input logic [7:0] b, input bit q);
        if (q) begin
            tick(b[7:4], 1'b1);
            tick(b[3:0], 1'b1);
        end else
            for (int i = 7; i >= 0; i--)
                tick({3'h0, b[i]}, 1'b0);
    endtask
    task automatic frame(input logic [15:0] w, input int nb, input bit q);
        #1 cs_n = 1'b0;
        #24;
        put(w[15:8], q);
        if (nb > 1)
            put(w[7:0], q);
        #24 cs_n = 1'b1;
        h_io = ~h_io;
        #60;
    endtask
    task automatic rd_wrap(input logic [23:0] a, input int dum, input int nb,
                           output logic [7:0] q[$]);
        logic [7:0] b;
        q = {};
        #1 cs_n = 1'b0;
        #24;
        put(8'h0C, 1'b1);
        for (int k = 2; k >= 0; k--)
            put(a[k*8 +: 8], 1'b1);
        repeat (dum) tick(~h_io, 1'b1);
        for (int j = 0; j < 2 * nb; j++) begin
            h_io = ~h_io;
            #24 sclk = 1'b1;
            b = {b[3:0], io};
            #24 sclk = 1'b0;
            if (j % 2 == 1)
                q.push_back(b);
        end
        #24 cs_n = 1'b1;
        #60;
    endtask
endmodule
`default_nettype wire

//--- verif/quad_mode_switch_and_soft_reset_test.sv
// bench for the flash mode controller: apb master plus serial host model
// assumes the array answers addr[7:0] ^ 5Ah at once
`timescale 1ns/1ps
`default_nettype none
module quad_mode_switch_and_soft_reset_test;
    import flash_cmd_pkg::*;
    localparam int RC = 200;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        cs_n, sclk, quad_mode, reset_busy;
    logic [7:0]  paddr, array_data;
    logic [31:0] pwdata, prdata;
    logic [3:0]  h_io, io_out, io_oe, io_w;
    logic [23:0] array_addr;
    int          bad_count, cmp_count;
    assign io_w = (io_oe & io_out) | (~io_oe & h_io);
    assign array_data = array_addr[7:0] ^ 8'h5A;
    always #2 pclk = ~pclk;
    flash_mode_ctrl #(.RST_COUNT(RC)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cs_n_pin(cs_n), .sclk_pin(sclk), .io_in(io_w),
        .io_out(io_out), .io_oe(io_oe), .array_addr(array_addr), .array_data(array_data),
        .quad_mode(quad_mode), .reset_busy(reset_busy));
    spi_host_model host (.cs_n(cs_n), .sclk(sclk), .h_io(h_io), .io(io_w));
    // --------
    // tasks
    // --------
    task automatic close_out;
        $display("mismatches %0d compares %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            bad_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x, input string n);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        chk(n, r, x);
    endtask
    task automatic rs(input logic [31:0] x);
        rc(ADDR_STATUS, x, "status");
    endtask
    task automatic op(input logic [7:0] c, input bit q);
        host.frame({c, 8'h00}, 1, q);
    endtask
    task automatic wait_idle;
        for (int n = 0; n < 1000 && reset_busy !== 1'b0; n++)
            @(posedge pclk);
        if (reset_busy !== 1'b0)
            bad_count++;
    endtask
    // --------
    // tests
    // --------
    initial begin
        #100000;
        bad_count++;
        close_out;
    end
    initial begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  q[$];
        logic [7:0]  p;
        int          w;
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rs(32'h0000_0000);
        rc(ADDR_PARAM, 32'h0000_0000, "param");
        apb(8'h20, 1'b0, 32'h0000_0000, r, e);
        chk("slverr", 32'(e), 32'h0000_0001);
        host.frame({OP_SET_PARAM, 8'h31}, 2, 1'b0);
        rc(ADDR_PARAM, 32'h0000_0000, "param");
        op(OP_ENTER_QUAD, 1'b0);
        rs(32'h0000_0000);
        apb(ADDR_CTRL, 1'b1, 32'h0000_00A7, r, e);
        apb(ADDR_MODE, 1'b1, 32'h0000_05C3, r, e);
        op(OP_ENTER_QUAD, 1'b0);
        rs(32'h0000_0001);
        rc(ADDR_CTRL, 32'h0000_00A7, "ctrl");
        rc(ADDR_MODE, 32'h0000_05C3, "mode");
        for (int s = 0; s < 4; s++) begin
            p = 8'((s << 4) | (3 - s));
            w = 8 << (3 - s);
            host.frame({OP_SET_PARAM, p}, 2, 1'b1);
            rc(ADDR_PARAM, 32'(p), "param");
            host.rd_wrap(24'h01_2300 + 24'(w - 2), 2 + 2 * s, 4, q);
            for (int i = 0; i < 4; i++)
                chk("rd byte", 32'(q[i]), 32'(8'((w - 2 + i) % w) ^ 8'h5A));
        end
        op(OP_RST_ENABLE, 1'b1);
        rs(32'h0000_0003);
        op(OP_ENTER_QUAD, 1'b1);
        op(OP_RESET, 1'b1);
        rs(32'h0000_0001);
        op(OP_EXIT_QUAD, 1'b1);
        rs(32'h0000_0000);
        rc(ADDR_CTRL, 32'h0000_00A7, "ctrl");
        rc(ADDR_MODE, 32'h0000_05C3, "mode");
        op(OP_ENTER_QUAD, 1'b0);
        rs(32'h0000_0001);
        op(OP_RST_ENABLE, 1'b1);
        op(OP_RESET, 1'b1);
        rs(32'h0000_0004);
        op(OP_RST_ENABLE, 1'b0);
        wait_idle();
        rs(32'h0000_0000);
        rc(ADDR_CTRL, 32'h0000_0001, "ctrl");
        rc(ADDR_MODE, 32'h0000_0000, "mode");
        rc(ADDR_PARAM, 32'h0000_0000, "param");
        op(OP_RST_ENABLE, 1'b0);
        op(OP_RESET, 1'b0);
        rs(32'h0000_0004);
        wait_idle();
        close_out;
    end
endmodule
`default_nettype wire
